// ---- rtl/speed_demand_pkg.sv ----
// Functional notes
// - demand rises zero to full scale over programmed accel time, 0.1 s steps
// - demand falls full scale to zero over separate programmed decel time
// - on entering drive demand starts at programmed creep frequency
// - forward frequency demand capped at programmed forward maximum
// - reverse frequency demand capped at independent programmed reverse maximum
// - mode input selects switches one and two as limits or inching
// - limit mode: first limit applies while switch one is open
// - limit mode: second limit applies while switch two is open
// - inching mode: drive at inching frequency while either switch closed
// - inching movement lasts at most the programmed inching duration
// - inching mode: no inching motion while both switches open
// - third limit applies on open or closed switch per polarity input
// - inverter keeps pulsing while foot switch closed with a drive direction selected, even at zero limit
package speed_demand_pkg;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLOCK_PERIOD_NS     = 100;
	localparam int TENTH_S_NS          = 100_000_000;
	localparam int TENTH_S_CYCLES_DEF  = TENTH_S_NS / CLOCK_PERIOD_NS;
	// ****************************************
	// frequency format: 1/16 Hz units
	// ****************************************
	localparam int FREQ_FRAC_BITS      = 4;
	localparam int FREQ_W              = 12;
	localparam int HZ_W                = 8;
	localparam int CREEP_W             = 10;
	localparam int TIME_W              = 7;
	localparam int FULL_SCALE_UNITS    = 4080;
	localparam logic [FREQ_W-1:0] FREQ_ZERO = 12'h000;
	// ****************************************
	// modes and polarity
	// ****************************************
	localparam logic MODE_LIMIT        = 1'h0;
	localparam logic MODE_JOG          = 1'h1;
	localparam logic POL_OPEN          = 1'h0;
	localparam logic SW_CLOSED         = 1'h1;
	localparam int   SW_COUNT          = 6;
	localparam int   SW_1              = 0;
	localparam int   SW_2              = 1;
	localparam int   SW_3              = 2;
	localparam int   SW_FOOT           = 3;
	localparam int   SW_FWD            = 4;
	localparam int   SW_REV            = 5;
endpackage : speed_demand_pkg

// ---- rtl/traction_speed_demand_limiter.sv ----
`timescale 1ns/1ps
module traction_speed_demand_limiter
	import speed_demand_pkg::*;
#(
	parameter int TENTH_S_CYCLES = TENTH_S_CYCLES_DEF
) (
	// clock and reset
	input  wire logic                clock,
	input  wire logic                rst,
	// vehicle switches, asynchronous, high = closed
	input  wire logic                limit_sw1,
	input  wire logic                limit_sw2,
	input  wire logic                limit_sw3,
	input  wire logic                foot_sw,
	input  wire logic                drive_fwd_sw,
	input  wire logic                drive_rev_sw,
	// programmed settings
	input  wire logic [TIME_W-1:0]   accel_time,
	input  wire logic [TIME_W-1:0]   decel_time,
	input  wire logic [CREEP_W-1:0]  creep_freq,
	input  wire logic [HZ_W-1:0]     forward_freq_cap,
	input  wire logic [HZ_W-1:0]     reverse_freq_cap,
	input  wire logic [HZ_W-1:0]     limit1_freq,
	input  wire logic [HZ_W-1:0]     limit2_freq,
	input  wire logic [HZ_W-1:0]     limit3_freq,
	input  wire logic [HZ_W-1:0]     jog_freq,
	input  wire logic [TIME_W-1:0]   jog_duration,
	input  wire logic                switch_mode,
	input  wire logic                limit3_polarity,
	// inverter side
	output logic      [FREQ_W-1:0]   freq_demand,
	output logic                     motor_reverse,
	output logic                     pulse_enable
);
	// ****************************************
	// derived counts
	// ****************************************
	localparam int STEP_BASE_I = (TENTH_S_CYCLES / FULL_SCALE_UNITS) > 0 ? (TENTH_S_CYCLES / FULL_SCALE_UNITS) : 1;
	localparam logic [14:0] STEP_BASE = 15'(STEP_BASE_I);
	localparam int TICK_W = $clog2(TENTH_S_CYCLES + 1);
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TENTH_S_CYCLES - 1);

	function automatic logic [FREQ_W-1:0] hz_units(input logic [HZ_W-1:0] hz);
		hz_units = {hz, 4'h0};
	endfunction : hz_units

	function automatic logic [FREQ_W-1:0] fmin(input logic [FREQ_W-1:0] a, input logic [FREQ_W-1:0] b);
		fmin = (a < b) ? a : b;
	endfunction : fmin

	// ****************************************
	// switch synchronisers
	// ****************************************
	logic [SW_COUNT-1:0] sw_raw;
	logic [SW_COUNT-1:0] sw_meta;
	logic [SW_COUNT-1:0] sw;
	assign sw_raw = {drive_rev_sw, drive_fwd_sw, foot_sw, limit_sw3, limit_sw2, limit_sw1};

	genvar gi;
	generate
		for (gi = 0; gi < SW_COUNT; gi++) begin : g_sync
			always_ff @(posedge clock) begin
				if (rst) begin
					sw_meta[gi] <= 1'h0;
					sw[gi]      <= 1'h0;
				end else begin
					sw_meta[gi] <= sw_raw[gi];
					sw[gi]      <= sw_meta[gi];
				end
			end
		end
	endgenerate

	// ****************************************
	// request decode
	// ****************************************
	logic [TICK_W-1:0] tick_cnt;
	logic [TIME_W-1:0] jog_tenths;
	logic              moving_q;
	logic [21:0]       step_cnt;

	wire jog_mode   = (switch_mode == MODE_JOG);
	wire drive_fwd  = sw[SW_FWD] & ~sw[SW_REV];
	wire drive_rev  = sw[SW_REV] & ~sw[SW_FWD];
	wire drive_req  = drive_fwd | drive_rev;
	wire jog_sw     = jog_mode & (sw[SW_1] | sw[SW_2]);
	wire jog_active = jog_sw & ~drive_req & (jog_tenths < jog_duration);
	wire want_rev   = drive_req ? drive_rev : (jog_active & ~sw[SW_1]);
	wire moving     = drive_req | jog_active;
	wire dir_change = (want_rev != motor_reverse) & (freq_demand != FREQ_ZERO);

	// ****************************************
	// target selection
	// ****************************************
	wire lim1_on = ~jog_mode & (sw[SW_1] != SW_CLOSED);
	wire lim2_on = ~jog_mode & (sw[SW_2] != SW_CLOSED);
	wire lim3_on = (sw[SW_3] == limit3_polarity);
	wire [FREQ_W-1:0] dir_cap = want_rev ? hz_units(reverse_freq_cap) : hz_units(forward_freq_cap);
	wire [FREQ_W-1:0] cap_a   = lim1_on ? fmin(dir_cap, hz_units(limit1_freq)) : dir_cap;
	wire [FREQ_W-1:0] cap_b   = lim2_on ? fmin(cap_a, hz_units(limit2_freq)) : cap_a;
	wire [FREQ_W-1:0] cap_c   = lim3_on ? fmin(cap_b, hz_units(limit3_freq)) : cap_b;
	wire [FREQ_W-1:0] target  = dir_change ? FREQ_ZERO :
	                            drive_req  ? cap_c :
	                            jog_active ? hz_units(jog_freq) : FREQ_ZERO;

	// ****************************************
	// ramp
	// ****************************************
	wire              entering  = moving & ~moving_q & (freq_demand == FREQ_ZERO);
	wire [FREQ_W-1:0] creep_u   = FREQ_W'(creep_freq);
	wire [FREQ_W-1:0] creep_val = fmin(creep_u, target);
	wire              rising    = freq_demand < target;
	// one unit per step; the step length is truncated, so full scale lands slightly early
	wire [21:0] step_len  = 22'(rising ? accel_time : decel_time) * 22'(STEP_BASE);
	wire        step_done = (step_cnt + 22'h00_0001) >= step_len;
	wire        accel_step = rising & step_done & ~entering;
	wire        decel_step = (freq_demand > target) & step_done & ~entering;
	wire [FREQ_W-1:0] next_demand = entering   ? creep_val :
	                                accel_step ? freq_demand + 12'h001 :
	                                decel_step ? freq_demand - 12'h001 : freq_demand;

	always_ff @(posedge clock) begin
		if (rst) begin
			step_cnt <= 22'h00_0000;
		end else if (entering | (freq_demand == target) | step_done) begin
			step_cnt <= 22'h00_0000;
		end else begin
			step_cnt <= step_cnt + 22'h00_0001;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			freq_demand   <= FREQ_ZERO;
			motor_reverse <= 1'h0;
			moving_q      <= 1'h0;
			pulse_enable  <= 1'h0;
		end else begin
			freq_demand   <= next_demand;
			moving_q      <= moving;
			// direction flips only once the motor has ramped to zero
			if (moving & (freq_demand == FREQ_ZERO))
				motor_reverse <= want_rev;
			pulse_enable  <= (next_demand != FREQ_ZERO) | jog_active | (sw[SW_FOOT] & drive_req);
		end
	end

	// ****************************************
	// inching timer
	// ****************************************
	// the tenth counter restarts with each press, so every movement gets full tenths
	always_ff @(posedge clock) begin
		if (rst | ~jog_sw) begin
			tick_cnt   <= '0;
			jog_tenths <= 7'h00;
		end else if (tick_cnt == TICK_LAST) begin
			tick_cnt   <= '0;
			if (jog_tenths < jog_duration)
				jog_tenths <= jog_tenths + 7'h01;
		end else begin
			tick_cnt   <= tick_cnt + TICK_W'(1);
		end
	end

	// ****************************************
	// check helpers
	// ****************************************
	// cycles since demand last moved; it stops at all ones so a long stand cannot wrap
	logic [21:0] since_move;

	always_ff @(posedge clock) begin
		if (rst | (next_demand != freq_demand)) begin
			since_move <= 22'h00_0000;
		end else if (~&since_move) begin
			since_move <= since_move + 22'h00_0001;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	AST_UP_BY_ONE: assert property (@(posedge clock) disable iff (rst)
		($past(freq_demand) != FREQ_ZERO && freq_demand > $past(freq_demand)) |-> freq_demand == $past(freq_demand) + 12'h001)
		else $error("demand rose by more than one unit");
	AST_UP_SPACING: assert property (@(posedge clock) disable iff (rst)
		accel_step |-> (&since_move) || (since_move + 22'h00_0001 >= 22'(accel_time) * 22'(STEP_BASE)))
		else $error("acceleration steps too close together");
	AST_DOWN_BY_ONE: assert property (@(posedge clock) disable iff (rst)
		(freq_demand < $past(freq_demand)) |-> freq_demand == $past(freq_demand) - 12'h001)
		else $error("demand fell by more than one unit");
	AST_CREEP_START: assert property (@(posedge clock) disable iff (rst)
		entering |=> freq_demand == $past(creep_val))
		else $error("drive entry did not start at creep");
	AST_NO_OVERSHOOT: assert property (@(posedge clock) disable iff (rst)
		(freq_demand > $past(freq_demand)) |-> freq_demand <= $past(target))
		else $error("demand rose above target");
	AST_FWD_CAP: assert property (@(posedge clock) disable iff (rst)
		(drive_fwd && !dir_change) |-> target <= hz_units(forward_freq_cap))
		else $error("forward target above cap");
	AST_REV_CAP: assert property (@(posedge clock) disable iff (rst)
		(drive_rev && !dir_change) |-> target <= hz_units(reverse_freq_cap))
		else $error("reverse target above cap");
	AST_LIMIT1: assert property (@(posedge clock) disable iff (rst)
		(!jog_mode && !sw[SW_1] && drive_req) |-> target <= hz_units(limit1_freq))
		else $error("first limit not applied");
	AST_LIMIT2: assert property (@(posedge clock) disable iff (rst)
		(!jog_mode && !sw[SW_2] && drive_req) |-> target <= hz_units(limit2_freq))
		else $error("second limit not applied");
	AST_LIMIT3: assert property (@(posedge clock) disable iff (rst)
		(sw[SW_3] == limit3_polarity && drive_req) |-> target <= hz_units(limit3_freq))
		else $error("third limit not applied");
	AST_JOG_FREQ: assert property (@(posedge clock) disable iff (rst)
		(jog_active && !dir_change) |-> target == hz_units(jog_freq))
		else $error("inching target wrong");
	AST_JOG_IDLE: assert property (@(posedge clock) disable iff (rst)
		(jog_mode && !sw[SW_1] && !sw[SW_2] && !drive_req) |-> target == FREQ_ZERO)
		else $error("inching with switches open");
	AST_JOG_TIME: assert property (@(posedge clock) disable iff (rst)
		jog_active |-> jog_tenths < jog_duration)
		else $error("inching past its duration");
	AST_FOOT_PULSE: assert property (@(posedge clock) disable iff (rst)
		(sw[SW_FOOT] && drive_req) |=> pulse_enable)
		else $error("pulsing dropped with foot switch closed");
endmodule : traction_speed_demand_limiter

// ---- test/vehicle_panel_model.sv ----
`timescale 1ns/1ps
// ****************************************
// switch panel and programmer model
// ****************************************
module vehicle_panel_model
	import speed_demand_pkg::*;
#(
	parameter int MOTOR_MAX_HZ = 200
) (
	// switches, high = closed
	output logic [SW_COUNT-1:0] sw,
	// programmed times
	output logic [TIME_W-1:0]   accel,
	output logic [TIME_W-1:0]   decel,
	output logic [TIME_W-1:0]   jog_dur,
	// programmed frequencies
	output logic [CREEP_W-1:0]  creep,
	output logic [HZ_W-1:0]     fwd_cap,
	output logic [HZ_W-1:0]     rev_cap,
	output logic [HZ_W-1:0]     lim1,
	output logic [HZ_W-1:0]     lim2,
	output logic [HZ_W-1:0]     lim3,
	output logic [HZ_W-1:0]     jog_hz,
	// mode and polarity
	output logic                mode,
	output logic                pol
);
	localparam int CAP_CEIL = MOTOR_MAX_HZ * 10 / 11;
	task automatic press(input logic [SW_COUNT-1:0] s);
		sw = s;
	endtask : press
	// caps held to at most ten elevenths of the motor maximum; lower requests pass as asked
	task automatic set_caps(input int f, input int r);
		fwd_cap = HZ_W'(f > CAP_CEIL ? CAP_CEIL : f);
		rev_cap = HZ_W'(r > CAP_CEIL ? CAP_CEIL : r);
	endtask : set_caps
	task automatic set_mode(input logic m);
		if (m == MODE_JOG) lim2 = 8'h00;
		mode = m;
	endtask : set_mode
	task automatic prog(input int a, d, c, l1, l2, l3, jh, jd, p);
		accel = TIME_W'(a);
		decel = TIME_W'(d);
		creep = CREEP_W'(c);
		lim1 = HZ_W'(l1);
		lim2 = HZ_W'(l2);
		lim3 = HZ_W'(l3);
		jog_hz = HZ_W'(jh);
		jog_dur = TIME_W'(jd);
		pol = p[0];
	endtask : prog
endmodule : vehicle_panel_model

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
	import speed_demand_pkg::*;
	typedef struct packed {logic [1:0] k; logic [FREQ_W-1:0] v;} note_s;
	logic                clock = 1'b0;
	logic                rst = 1'b1;
	logic [SW_COUNT-1:0] sw;
	logic [TIME_W-1:0]   accel, decel, jog_dur;
	logic [CREEP_W-1:0]  creep;
	logic [HZ_W-1:0]     fwd_cap, rev_cap, lim1, lim2, lim3, jog_hz, rv;
	logic                mode, pol, motor_reverse, pulse_enable;
	logic [FREQ_W-1:0]   freq_demand, v0;
	logic [5:0]          pr [5] = '{6'h12, 6'h11, 6'h10, 6'h17, 6'h13};
	note_s               q [$];
	note_s               nt;
	event                got;
	int                  n_mismatch = 0, tests_run = 0, cyc = 0, e, cr, rc, jh;
	// ****************************************
	// parts
	// ****************************************
	vehicle_panel_model i_vehicle_panel_model (.sw(sw), .accel(accel), .decel(decel), .jog_dur(jog_dur),
		.creep(creep), .fwd_cap(fwd_cap), .rev_cap(rev_cap), .lim1(lim1), .lim2(lim2), .lim3(lim3),
		.jog_hz(jog_hz), .mode(mode), .pol(pol));
	// ramp step base of one cycle per unit for each programmed tenth keeps the tenth-second figures exact
	traction_speed_demand_limiter #(.TENTH_S_CYCLES(4080)) i_traction_speed_demand_limiter (.clock(clock),
		.rst(rst), .limit_sw1(sw[SW_1]), .limit_sw2(sw[SW_2]), .limit_sw3(sw[SW_3]), .foot_sw(sw[SW_FOOT]),
		.drive_fwd_sw(sw[SW_FWD]), .drive_rev_sw(sw[SW_REV]), .accel_time(accel), .decel_time(decel),
		.creep_freq(creep), .forward_freq_cap(fwd_cap), .reverse_freq_cap(rev_cap), .limit1_freq(lim1),
		.limit2_freq(lim2), .limit3_freq(lim3), .jog_freq(jog_hz), .jog_duration(jog_dur),
		.switch_mode(mode), .limit3_polarity(pol), .freq_demand(freq_demand),
		.motor_reverse(motor_reverse), .pulse_enable(pulse_enable));
	initial forever #50 clock = ~clock;
	always @(posedge clock) begin
		cyc++;
		if (cyc == 30000) begin
			n_mismatch++;
			wrap_up();
		end
	end
	// ****************************************
	// helpers
	// ****************************************
	task automatic cyc_n(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : cyc_n
	task automatic note(input logic [1:0] k, input int v);
		q.push_back('{k, FREQ_W'(v)});
		->got;
	endtask : note
	task automatic bad(input int k, input logic [FREQ_W-1:0] a, b);
		$display("[FAIL] %0t kind %0d got %0d exp %0d", $time, k, a, b);
		n_mismatch++;
	endtask : bad
	task automatic cmp_freq(input logic [FREQ_W-1:0] x);
		tests_run++;
		if (freq_demand !== x) bad(0, freq_demand, x);
	endtask : cmp_freq
	task automatic cmp_bit(input int k, input logic a, x);
		tests_run++;
		if (a !== x) bad(k, a, x);
	endtask : cmp_bit
	// stable for a dozen cycles means the ramp has reached its target
	task automatic settle();
		int same;
		logic [FREQ_W-1:0] last;
		same = 0;
		last = freq_demand;
		for (int i = 0; i < 6000 && same < 12; i++) begin
			cyc_n(1);
			same = (freq_demand === last) ? same + 1 : 0;
			last = freq_demand;
		end
	endtask : settle
	task automatic wait_change(input logic [FREQ_W-1:0] v);
		for (int i = 0; i < 50 && freq_demand === v; i++) cyc_n(1);
	endtask : wait_change
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : wrap_up
	initial forever begin
		@got;
		while (q.size() > 0) begin
			nt = q.pop_front();
			if (nt.k == 2'h0) cmp_freq(nt.v);
			else cmp_bit(nt.k, nt.k == 2'h1 ? motor_reverse : pulse_enable, nt.v[0]);
		end
	end
	// ****************************************
	// tests
	// ****************************************
	initial begin
		void'($urandom(32'hb3c6a9a2));
		cr = 16 + $urandom % 256;
		rc = 10 + $urandom % 10;
		jh = 1 + $urandom % 25;
		i_vehicle_panel_model.prog(3, 2, cr, 255, 255, 255, jh, 2, 0);
		i_vehicle_panel_model.set_caps(20, rc);
		i_vehicle_panel_model.set_mode(MODE_LIMIT);
		i_vehicle_panel_model.press(6'h03);
		cyc_n(2);
		rst = 1'b0;
		note(0, 0);
		note(2, 0);
		i_vehicle_panel_model.press(6'h13);
		wait_change(0);
		note(0, cr);
		cyc_n(30);
		note(0, cr + 10);
		settle();
		note(0, 320);
		note(2, 1);
		$display("forward drive test done");
		for (int c = 0; c < 5; c++) begin
			rv = HZ_W'(1 + $urandom % 18);
			e = (c == 4) ? 20 : (c == 1 ? rv + 1 : rv);
			i_vehicle_panel_model.prog(3, 2, cr, c == 1 ? 255 : rv, c == 0 ? 255 : rv + 1,
				c >= 3 ? rv : 255, jh, 2, c >= 3);
			i_vehicle_panel_model.press(pr[c]);
			if (c != 4) begin
				wait_change(320);
				v0 = freq_demand;
				cyc_n(30);
				note(0, v0 - 15);
			end
			settle();
			note(0, e * 16);
			i_vehicle_panel_model.prog(3, 2, cr, 255, 255, 255, jh, 2, 0);
			i_vehicle_panel_model.press(6'h13);
			settle();
		end
		$display("speed limit test done");
		i_vehicle_panel_model.press(6'h23);
		settle();
		note(0, rc * 16);
		note(1, 1);
		$display("reverse test done");
		i_vehicle_panel_model.prog(3, 2, cr, 255, 255, 0, jh, 2, 0);
		i_vehicle_panel_model.press(6'h2b);
		settle();
		note(0, 0);
		note(2, 1);
		i_vehicle_panel_model.press(6'h23);
		cyc_n(5);
		note(2, 0);
		$display("foot switch test done");
		i_vehicle_panel_model.press(6'h00);
		i_vehicle_panel_model.set_mode(MODE_JOG);
		settle();
		note(0, 0);
		note(2, 0);
		i_vehicle_panel_model.press(6'h01);
		wait_change(0);
		note(0, cr < jh * 16 ? cr : jh * 16);
		settle();
		note(0, jh * 16);
		note(1, 0);
		// still inside the two tenths of the movement, whatever the ramp took
		cyc_n(6500);
		note(0, jh * 16);
		cyc_n(2000);
		settle();
		note(0, 0);
		// release restarts the timer, so the reverse press gets a fresh movement
		i_vehicle_panel_model.press(6'h00);
		cyc_n(5);
		i_vehicle_panel_model.press(6'h02);
		settle();
		note(0, jh * 16);
		note(1, 1);
		$display("inching test done");
		wrap_up();
	end
endmodule : tb_top
